/* core/nfc_pkg.sv */
`default_nettype none

package nfc_pkg;

    // bus geometry
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;

    // density and the two upper address bits that depend on it
    localparam int DENSITY_MB = 128;
    localparam int TOP_ADDRESS_BIT_MIN_MB = 128;
    localparam int SECOND_ADDRESS_BIT_MIN_MB = 64;
    localparam int TOP_ADDRESS_BIT = 22;
    localparam int SECOND_ADDRESS_BIT = 21;

    // 8Mb banks of x16 words: 2^19 words each
    localparam int BANK_LSB = 19;
    localparam int BANK_W = 4;
    localparam int NUM_BANKS = 16;

    // protection granule: one lock pair per bank
    localparam int LOCK_BLOCKS = NUM_BANKS;

    // lock command codes
    localparam logic [1:0] LK_LOCK = 2'h1;
    localparam logic [1:0] LK_UNLOCK = 2'h2;
    localparam logic [1:0] LK_DOWN = 2'h3;

    // configuration register
    localparam logic [DATA_W-1:0] CFG_DEFAULT = 16'hFFFF;

    // word shown while reading a bank busy with program or erase
    localparam logic [DATA_W-1:0] STATUS_BUSY = 16'h0000;

    // one-time-programmable area followed by the unique number
    localparam int OTP_BITS = 2112;
    localparam int UID_BITS = 64;
    localparam int OTP_DEPTH = OTP_BITS / DATA_W;
    localparam int UID_WORDS = UID_BITS / DATA_W;
    localparam int OTP_AW = 8;
    localparam logic [OTP_AW-1:0] OTP_END = 8'h84;
    localparam logic [OTP_AW-1:0] UID_END = 8'h88;
    localparam logic [DATA_W-1:0] OTP_ERASED = 16'hFFFF;

    typedef enum logic [2:0] {
        NFC_MODE_RESET = 3'b001,
        NFC_MODE_STANDBY = 3'b010,
        NFC_MODE_ACTIVE = 3'b100
    } nfc_mode_t;

endpackage : nfc_pkg

`default_nettype wire

/* core/nfc_flash_pins.sv */
// How it works
// R1: chip select low with reset pin high puts the die in active mode.
// R2: chip select high deselects, tri-states data outputs, gives standby.
// R3: data outputs drive on a read only while the output gate is low.
// R4: write address and data latch at first rising edge of select or strobe.
// R5: lock guard low: locked-down blocks keep their protection state.
// R6: lock guard high: locked-down blocks may be locked or unlocked.
// R7: reset pin low holds reset mode with outputs tri-stated.
// R8: after hardware reset all blocks lock and configuration returns to default.
// R9: leaving reset gives async read; host needs a select fall before trusting data.
// R10: program voltage sampled at operation start, later changes ignored.
// R11: program and erase refused while voltage is below lockout level.
// R12: host never enables both dies on the shared data bus.
// R13: host uses top and second address bits only on large densities.
// R14: every block starts locked at power-up; any set may be relocked.
// R15: 8Mb banks let one bank program while others are read.
// R16: 2112 user one-time-programmable bits plus a 64-bit unique number.
`default_nettype none

module nfc_flash_pins #(
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // arbitrary value
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // parallel bus pins
    input wire logic chip_sel_n_i,
    input wire logic out_gate_n_i,
    input wire logic write_n_i,
    input wire logic hard_reset_n_i,
    input wire logic lock_guard_n_i,
    input wire logic above_program_lockout_level_i,
    input wire logic [nfc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [nfc_pkg::DATA_W-1:0] dq_i,
    output logic [nfc_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    // array read path
    output logic [nfc_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic [nfc_pkg::DATA_W-1:0] rd_data_i,
    // latched bus writes
    output logic wr_stb_o,
    output logic [nfc_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [nfc_pkg::DATA_W-1:0] wr_data_o,
    // program and erase operations
    input wire logic op_start_i,
    input wire logic [nfc_pkg::BANK_W-1:0] op_bank_i,
    input wire logic [nfc_pkg::NUM_BANKS-1:0] op_done_i,
    output logic op_refused_o,
    output logic [nfc_pkg::NUM_BANKS-1:0] bank_busy_o,
    // block protection
    input wire logic lock_req_i,
    input wire logic [1:0] lock_cmd_i,
    input wire logic [nfc_pkg::BANK_W-1:0] lock_blk_i,
    output logic lock_refused_o,
    output logic [nfc_pkg::LOCK_BLOCKS-1:0] lock_o,
    output logic [nfc_pkg::LOCK_BLOCKS-1:0] lockdown_o,
    // configuration register
    input wire logic cfg_wr_i,
    input wire logic [nfc_pkg::DATA_W-1:0] cfg_data_i,
    output logic [nfc_pkg::DATA_W-1:0] cfg_o,
    // one-time-programmable area and unique number
    input wire logic otp_prog_i,
    input wire logic [nfc_pkg::OTP_AW-1:0] otp_addr_i,
    input wire logic [nfc_pkg::DATA_W-1:0] otp_data_i,
    output logic [nfc_pkg::DATA_W-1:0] otp_rd_data_o,
    // die state
    output logic [2:0] mode_o,
    output logic data_valid_o
);

    typedef struct packed {
        nfc_pkg::nfc_mode_t mode;
        logic cs_n_prev;
        logic we_n_prev;
        logic [nfc_pkg::ADDR_W-1:0] addr_prev;
        logic [nfc_pkg::DATA_W-1:0] data_prev;
        logic rd_armed;
        logic drive;
        logic [nfc_pkg::DATA_W-1:0] dq;
        logic wr_stb;
        logic [nfc_pkg::ADDR_W-1:0] wr_addr;
        logic [nfc_pkg::DATA_W-1:0] wr_data;
        logic [nfc_pkg::LOCK_BLOCKS-1:0] lock;
        logic [nfc_pkg::LOCK_BLOCKS-1:0] lockdown;
        logic [nfc_pkg::DATA_W-1:0] cfg;
        logic [nfc_pkg::NUM_BANKS-1:0] busy;
        logic op_refused;
        logic lock_refused;
        logic [nfc_pkg::DATA_W-1:0] otp_rd_data;
    } nfc_state_t;

    // reserved upper bits read as zero on smaller densities
    localparam logic [nfc_pkg::ADDR_W-1:0] ADDR_MASK =
        ~((nfc_pkg::DENSITY_MB < nfc_pkg::TOP_ADDRESS_BIT_MIN_MB ?
           (23'h000001 << nfc_pkg::TOP_ADDRESS_BIT) : 23'h000000) |
          (nfc_pkg::DENSITY_MB < nfc_pkg::SECOND_ADDRESS_BIT_MIN_MB ?
           (23'h000001 << nfc_pkg::SECOND_ADDRESS_BIT) : 23'h000000)); // R13

    function automatic nfc_state_t rst_state();
        nfc_state_t s;
        s = '0;
        s.mode = nfc_pkg::NFC_MODE_RESET; // R7
        s.cs_n_prev = 1'b1;
        s.we_n_prev = 1'b1;
        s.lock = '1; // R8 R14
        s.cfg = nfc_pkg::CFG_DEFAULT; // R8
        return s;
    endfunction

    nfc_state_t q;
    nfc_state_t d;
    logic otp_we;
    logic [nfc_pkg::DATA_W-1:0] otp_mem [nfc_pkg::OTP_DEPTH];
    logic [nfc_pkg::BANK_W-1:0] rd_bank;
    logic [1:0] uid_idx;

    assign rd_bank = q.addr_prev[nfc_pkg::BANK_LSB +: nfc_pkg::BANK_W];
    assign uid_idx = 2'(otp_addr_i - nfc_pkg::OTP_END);

    always_comb begin
        d = q;
        otp_we = 1'b0;
        d.wr_stb = 1'b0;
        d.op_refused = 1'b0;
        d.lock_refused = 1'b0;
        d.cs_n_prev = chip_sel_n_i;
        d.we_n_prev = write_n_i;
        d.addr_prev = addr_i & ADDR_MASK;
        d.data_prev = dq_i;
        if (!hard_reset_n_i) begin
            d = rst_state(); // R7 R8
            d.cs_n_prev = chip_sel_n_i; // R9
        end else begin
            // select alone decides active or standby
            case (chip_sel_n_i)
                1'b0: d.mode = nfc_pkg::NFC_MODE_ACTIVE; // R1
                1'b1: d.mode = nfc_pkg::NFC_MODE_STANDBY; // R2
                default: d.mode = nfc_pkg::NFC_MODE_STANDBY;
            endcase
            if (q.cs_n_prev && !chip_sel_n_i) begin
                d.rd_armed = 1'b1; // R9
            end
            d.drive = !chip_sel_n_i && !out_gate_n_i && write_n_i; // R2 R3
            if (q.busy[rd_bank]) begin
                d.dq = nfc_pkg::STATUS_BUSY; // R15
            end else begin
                d.dq = rd_data_i;
            end
            // both low last cycle, one rising now: only the first edge latches
            if (!q.cs_n_prev && !q.we_n_prev && (chip_sel_n_i || write_n_i)) begin
                d.wr_stb = 1'b1; // R4
                d.wr_addr = q.addr_prev;
                d.wr_data = q.data_prev;
            end
            if (lock_req_i) begin
                if (q.lockdown[lock_blk_i] && !lock_guard_n_i) begin
                    d.lock_refused = 1'b1; // R5
                end else begin
                    case (lock_cmd_i)
                        nfc_pkg::LK_LOCK: d.lock[lock_blk_i] = 1'b1; // R6 R14
                        nfc_pkg::LK_UNLOCK: d.lock[lock_blk_i] = 1'b0; // R6
                        nfc_pkg::LK_DOWN: begin
                            d.lock[lock_blk_i] = 1'b1;
                            d.lockdown[lock_blk_i] = 1'b1;
                        end
                        default: d.lock_refused = 1'b1;
                    endcase
                end
            end
            if (cfg_wr_i) begin
                d.cfg = cfg_data_i;
            end
            // completion first, but a start on a bank busy last cycle is refused even if it completes now
            d.busy = q.busy & ~op_done_i; // R10
            if (op_start_i) begin
                if (!above_program_lockout_level_i || q.lock[op_bank_i]
                        || q.busy[op_bank_i]) begin
                    d.op_refused = 1'b1; // R11
                end else begin
                    d.busy[op_bank_i] = 1'b1; // R10 R15
                end
            end
            if (otp_prog_i) begin
                if (!above_program_lockout_level_i || otp_addr_i >= nfc_pkg::OTP_END) begin
                    d.op_refused = 1'b1; // R11 R16
                end else begin
                    otp_we = 1'b1; // R16
                end
            end
        end
        if (otp_addr_i < nfc_pkg::OTP_END) begin
            d.otp_rd_data = otp_mem[otp_addr_i]; // R16
        end else if (otp_addr_i < nfc_pkg::UID_END) begin
            d.otp_rd_data = UNIQUE_ID[uid_idx * nfc_pkg::DATA_W +: nfc_pkg::DATA_W]; // R16
        end else begin
            d.otp_rd_data = nfc_pkg::OTP_ERASED;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= rst_state(); // R14
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    // programming only clears bits, as in a real cell
    genvar gi;
    generate
        for (gi = 0; gi < nfc_pkg::OTP_DEPTH; gi++) begin : g_otp
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    otp_mem[gi] <= nfc_pkg::OTP_ERASED;
                end else if (clk_en_i && otp_we && otp_addr_i == 8'(gi)) begin
                    otp_mem[gi] <= otp_mem[gi] & otp_data_i; // R16
                end
            end
        end
    endgenerate

    assign dq_o = q.dq;
    assign dq_oe_n_o = !q.drive; // R2 R3 R7
    assign rd_addr_o = q.addr_prev;
    assign wr_stb_o = q.wr_stb;
    assign wr_addr_o = q.wr_addr;
    assign wr_data_o = q.wr_data;
    assign op_refused_o = q.op_refused;
    assign bank_busy_o = q.busy;
    assign lock_refused_o = q.lock_refused;
    assign lock_o = q.lock;
    assign lockdown_o = q.lockdown;
    assign cfg_o = q.cfg;
    assign otp_rd_data_o = q.otp_rd_data;
    assign mode_o = q.mode;
    assign data_valid_o = q.rd_armed; // R9

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_run;
        clk_en_i && hard_reset_n_i;
    endsequence

    sequence s_both_low;
        clk_en_i && hard_reset_n_i && !chip_sel_n_i && !write_n_i;
    endsequence

    sequence s_first_rise;
        clk_en_i && hard_reset_n_i && (chip_sel_n_i || write_n_i);
    endsequence

    a_active_mode: assert property ( // R1
        s_run and !chip_sel_n_i |=> mode_o == nfc_pkg::NFC_MODE_ACTIVE)
        else $error("selected die not in active mode");

    a_deselect_tristate: assert property ( // R2
        s_run and chip_sel_n_i |=> dq_oe_n_o && mode_o == nfc_pkg::NFC_MODE_STANDBY)
        else $error("deselected die drives or is not in standby");

    a_gate_drive: assert property ( // R3
        !dq_oe_n_o && $past(clk_en_i) |-> !$past(out_gate_n_i) && $past(write_n_i))
        else $error("data driven without output gate");

    a_write_latch: assert property ( // R4
        s_both_low ##1 s_first_rise |=>
            wr_stb_o && wr_data_o == $past(dq_i, 2) && wr_addr_o == $past(addr_i, 2))
        else $error("write not latched at first rising edge");

    a_write_once: assert property ( // R4
        s_both_low ##1 s_first_rise ##1 (clk_en_i && hard_reset_n_i) |=> !wr_stb_o)
        else $error("second rising edge latched again");

    a_lockdown_hold: assert property ( // R5
        s_run and !lock_guard_n_i && lock_req_i && lockdown_o[lock_blk_i] |=>
            lock_refused_o && lock_o == $past(lock_o))
        else $error("locked-down block changed with guard low");

    a_guard_unlock: assert property ( // R6
        s_run and lock_guard_n_i && lock_req_i && lock_cmd_i == nfc_pkg::LK_UNLOCK |=>
            !lock_o[$past(lock_blk_i)] && !lock_refused_o)
        else $error("unlock refused with guard high");

    a_reset_state: assert property ( // R7
        clk_en_i && !hard_reset_n_i |=>
            dq_oe_n_o && mode_o == nfc_pkg::NFC_MODE_RESET && !wr_stb_o)
        else $error("reset mode not entered");

    a_reset_locks: assert property ( // R8
        clk_en_i && !hard_reset_n_i |=> lock_o == '1 && cfg_o == nfc_pkg::CFG_DEFAULT)
        else $error("blocks not locked after reset");

    a_arm_after_reset: assert property ( // R9
        clk_en_i && !hard_reset_n_i ##1 (s_run and chip_sel_n_i) ##1 (s_run and !chip_sel_n_i)
            |=> data_valid_o)
        else $error("select fall did not validate data");

    a_vpp_refuse: assert property ( // R11
        s_run and op_start_i && !above_program_lockout_level_i |=>
            op_refused_o && bank_busy_o[$past(op_bank_i)] == $past(bank_busy_o[op_bank_i]))
        else $error("operation accepted below lockout level");

    a_vpp_ignored: assert property ( // R10
        s_run and bank_busy_o[op_bank_i] && !op_done_i[op_bank_i]
            && !above_program_lockout_level_i |=> bank_busy_o[$past(op_bank_i)])
        else $error("running operation stopped by voltage change");

endmodule // nfc_flash_pins

`default_nettype wire

/* test/nfc_host_model.sv */
`default_nettype none

module nfc_host_model (
    // clock
    input wire logic clk_i,
    // bus pins
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [nfc_pkg::ADDR_W-1:0] addr_o,
    output logic [nfc_pkg::DATA_W-1:0] dq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        addr_o = 23'h000000;
        dq_o = 16'h0000;
    end

    // every access starts from idle, so select always falls fresh
    task automatic rd(input logic [22:0] a, input logic g_n);
        @(posedge clk_i) #1;
        cs_n_o = 1'b0;
        oe_n_o = g_n;
        addr_o = a;
        dq_o = ~dq_o;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        @(posedge clk_i) #1;
        cs_n_o = 1'b0;
        we_n_o = 1'b0;
        addr_o = a;
        dq_o = d;
        @(posedge clk_i) #1;
        we_n_o = 1'b1;
        @(posedge clk_i) #1;
    endtask

    // released bus shows a changing pattern, not the last value
    task automatic idle();
        @(posedge clk_i) #1;
        cs_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        dq_o = ~dq_o;
    endtask
endmodule // nfc_host_model

`default_nettype wire

/* test/nfc_flash_pins_tb.sv */
`default_nettype none

module nfc_flash_pins_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hr_n = 1'b1;
    logic en = 1'b1;
    logic guard_n = 1'b1;
    logic volt = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic otp_prog_i = 1'b0;
    logic op_start_i = 1'b0;
    logic lock_req_i = 1'b0;
    logic [1:0] lock_cmd_i = 2'h0;
    logic [3:0] lock_blk_i = 4'h0;
    logic [3:0] op_bank_i = 4'h0;
    logic [7:0] otp_addr_i = 8'h00;
    logic [15:0] cfg_data_i = 16'h0000;
    logic [15:0] otp_data_i = 16'h0000;
    logic [15:0] op_done_i = 16'h0000;
    logic cs_n, oe_n, we_n, dq_oe_n_o, wr_stb_o, op_refused_o, lock_refused_o, data_valid_o;
    logic [22:0] addr, rd_addr_o, wr_addr_o;
    logic [15:0] dq_in, dq_o, rd_data_i, wr_data_o, bank_busy_o, lock_o, lockdown_o;
    logic [15:0] cfg_o, otp_rd_data_o;
    logic [2:0] mode_o;
    int error_cnt = 0;
    int checked = 0;

    always #4 clk_i = ~clk_i;
    assign rd_data_i = rd_addr_o[15:0] ^ 16'h5A5A;

    nfc_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n),
        .addr_o(addr), .dq_o(dq_in));

    nfc_flash_pins #(.UNIQUE_ID(64'h0011223344556677)) dut ( // arbitrary value
        .clk_i(clk_i), .rstn_i(rstn_i), .clk_en_i(en), .chip_sel_n_i(cs_n),
        .out_gate_n_i(oe_n), .write_n_i(we_n), .hard_reset_n_i(hr_n),
        .lock_guard_n_i(guard_n), .above_program_lockout_level_i(volt), .addr_i(addr),
        .dq_i(dq_in), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .rd_addr_o(rd_addr_o),
        .rd_data_i(rd_data_i), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o),
        .wr_data_o(wr_data_o), .op_start_i(op_start_i), .op_bank_i(op_bank_i),
        .op_done_i(op_done_i), .op_refused_o(op_refused_o), .bank_busy_o(bank_busy_o),
        .lock_req_i(lock_req_i), .lock_cmd_i(lock_cmd_i), .lock_blk_i(lock_blk_i),
        .lock_refused_o(lock_refused_o), .lock_o(lock_o), .lockdown_o(lockdown_o),
        .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i), .cfg_o(cfg_o),
        .otp_prog_i(otp_prog_i), .otp_addr_i(otp_addr_i), .otp_data_i(otp_data_i),
        .otp_rd_data_o(otp_rd_data_o), .mode_o(mode_o), .data_valid_o(data_valid_o));

    task automatic chk(input logic [22:0] g, input logic [22:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one-cycle request pulse; fields are set by the caller
    task automatic hit(input logic [3:0] k, input logic [15:0] dn);
        @(posedge clk_i) #1;
        {cfg_wr_i, otp_prog_i, op_start_i, lock_req_i} = k;
        op_done_i = dn;
        @(posedge clk_i) #1;
        {cfg_wr_i, otp_prog_i, op_start_i, lock_req_i} = 4'h0;
        op_done_i = 16'h0000;
    endtask

    task automatic lk(input logic [1:0] c, input logic [3:0] b, input logic [15:0] e,
        input logic rf);
        lock_cmd_i = c;
        lock_blk_i = b;
        hit(4'h1, 16'h0000);
        chk(lock_o, e);
        chk(lock_refused_o, rf);
    endtask

    task automatic t_read();
        host.rd(23'h045678, 1'b0);
        chk(mode_o, 3'b100);
        chk(dq_oe_n_o, 1'b0);
        chk(dq_o, 16'h5678 ^ 16'h5A5A);
        chk(data_valid_o, 1'b1);
        host.idle();
        host.rd(23'h000010, 1'b1);
        chk(dq_oe_n_o, 1'b1);
        host.idle();
        repeat (2) @(posedge clk_i);
        #1;
        chk(mode_o, 3'b010);
        chk(dq_oe_n_o, 1'b1);
        $display("read test done");
    endtask

    task automatic t_write();
        host.wr(23'h7ABCDE, 16'hC3A5);
        chk(wr_stb_o, 1'b1);
        chk(wr_addr_o, 23'h7ABCDE);
        chk(wr_data_o, 16'hC3A5);
        host.idle();
        chk(wr_stb_o, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        chk(wr_stb_o, 1'b0);
        $display("write test done");
    endtask

    task automatic t_lock();
        lk(2'h2, 4'h3, 16'hFFF7, 1'b0);
        lk(2'h1, 4'h3, 16'hFFFF, 1'b0);
        lk(2'h2, 4'h3, 16'hFFF7, 1'b0);
        lk(2'h3, 4'h4, 16'hFFF7, 1'b0);
        chk(lockdown_o, 16'h0010);
        guard_n = 1'b0;
        lk(2'h2, 4'h4, 16'hFFF7, 1'b1);
        guard_n = 1'b1;
        lk(2'h2, 4'h4, 16'hFFE7, 1'b0);
        // enable low freezes the request and its answer
        en = 1'b0;
        lk(2'h1, 4'h3, 16'hFFE7, 1'b0);
        en = 1'b1;
        lk(2'h0, 4'h5, 16'hFFE7, 1'b1);
        $display("lock test done");
    endtask

    task automatic t_ops();
        op_bank_i = 4'h3;
        hit(4'h2, 16'h0000);
        chk(op_refused_o, 1'b1);
        volt = 1'b1;
        hit(4'h2, 16'h0000);
        chk(bank_busy_o, 16'h0008);
        volt = 1'b0;
        host.rd(23'h180020, 1'b0);
        chk(dq_o, nfc_pkg::STATUS_BUSY);
        host.idle();
        host.rd(23'h281234, 1'b0);
        chk(dq_o, 16'h1234 ^ 16'h5A5A);
        host.idle();
        chk(bank_busy_o, 16'h0008);
        hit(4'h0, 16'h0008);
        chk(bank_busy_o, 16'h0000);
        $display("operation test done");
    endtask

    task automatic t_otp();
        volt = 1'b1;
        otp_addr_i = 8'h05;
        otp_data_i = 16'h12C4;
        hit(4'h4, 16'h0000);
        otp_data_i = 16'hF0FF;
        hit(4'h4, 16'h0000);
        @(posedge clk_i) #1;
        chk(otp_rd_data_o, 16'h10C4);
        otp_addr_i = 8'h84;
        hit(4'h4, 16'h0000);
        chk(op_refused_o, 1'b1);
        chk(otp_rd_data_o, 16'h6677);
        otp_addr_i = 8'h87;
        @(posedge clk_i) #1;
        chk(otp_rd_data_o, 16'h0011);
        $display("otp test done");
    endtask

    task automatic t_hard_reset();
        cfg_data_i = 16'h1234;
        hit(4'h8, 16'h0000);
        chk(cfg_o, 16'h1234);
        hr_n = 1'b0;
        host.rd(23'h000040, 1'b0);
        chk(mode_o, 3'b001);
        chk(dq_oe_n_o, 1'b1);
        chk(lock_o, 16'hFFFF);
        chk(lockdown_o, 16'h0000);
        chk(cfg_o, nfc_pkg::CFG_DEFAULT);
        chk(data_valid_o, 1'b0);
        host.idle();
        hr_n = 1'b1;
        host.rd(23'h000040, 1'b0);
        chk(data_valid_o, 1'b1);
        host.idle();
        $display("hard reset test done");
    endtask

    task automatic complete_run();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(8 * 3000);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        chk(lock_o, 16'hFFFF);
        chk(cfg_o, nfc_pkg::CFG_DEFAULT);
        chk(data_valid_o, 1'b0);
        rstn_i = 1'b1;
        t_read();
        t_write();
        t_lock();
        t_ops();
        t_otp();
        t_hard_reset();
        complete_run();
    end
endmodule // nfc_flash_pins_tb

`default_nettype wire
